/* logic/eespi_defines.svh */
`ifndef EESPI_DEFINES_SVH
`define EESPI_DEFINES_SVH

// ************************************************************
// Opcodes
// ************************************************************
`define EESPI_OPC_SET_WE 8'h06
`define EESPI_OPC_CLR_WE 8'h04
`define EESPI_OPC_RD_STAT 8'h05
`define EESPI_OPC_WR_STAT 8'h01
`define EESPI_OPC_RD_MEM 8'h03
`define EESPI_OPC_WR_MEM 8'h02

// ************************************************************
// Status byte fields
// ************************************************************
`define EESPI_SB_GUARD 7
`define EESPI_SB_IDSEL 6
`define EESPI_SB_ZERO 5
`define EESPI_SB_LOCK 4
`define EESPI_SB_BP_HI 3
`define EESPI_SB_BP_LO 2
`define EESPI_SB_WEL 1
`define EESPI_SB_BUSY 0

// ************************************************************
// Protection ranges and sizes
// ************************************************************
`define EESPI_BP_QTR 2'h1
`define EESPI_BP_HALF 2'h2
`define EESPI_BP_FULL 2'h3
`define EESPI_PROT_QTR 17'h18000
`define EESPI_PROT_HALF 17'h10000
`define EESPI_ADDR_W 17
`define EESPI_ADDR_LAST 2'h2
`define EESPI_PAGE 256
`define EESPI_MEM_BYTES 131072

// ************************************************************
// Timing
// ************************************************************
`define EESPI_CLK_NS 5
`define EESPI_T_WC_NS 5000000
`define EESPI_T_WC_CYC (`EESPI_T_WC_NS / `EESPI_CLK_NS)
`define EESPI_TMR_W 20

`endif

/* logic/eespi_pkg.sv */
`include "eespi_defines.svh"
package eespi_pkg;

	// ************************************************************
	// Link side
	// ************************************************************
	typedef enum logic [2:0] {
		LK_OPC, LK_ADDR, LK_WDATA, LK_RDATA, LK_RSTAT, LK_WSTAT, LK_IGN
	} eespi_link_st_t;

	typedef enum logic [2:0] {
		CMD_NONE, CMD_SET_WE, CMD_CLR_WE, CMD_WR_STAT, CMD_RD_MEM, CMD_WR_MEM
	} eespi_cmd_t;

	typedef struct packed {
		logic guard_enable;
		logic id_page_select;
		logic zero;
		logic id_page_lock;
		logic block_protect_hi;
		logic block_protect_lo;
		logic write_enable_latch;
		logic busy;
	} eespi_status_t;

	typedef struct packed {
		eespi_link_st_t st;
		logic [2:0] bitcnt;
		logic [1:0] bytecnt;
		logic [7:0] sh;
		logic [`EESPI_ADDR_W-1:0] addr;
		logic [7:0] tx;
		eespi_status_t stat_s1;
		eespi_status_t stat_s2;
	} eespi_frame_t;

	typedef struct packed {
		logic seq;
		eespi_cmd_t cmd;
		logic exact;
		logic [7:0] stat_val;
		logic stat_full;
		logic [`EESPI_ADDR_W-1:0] wbase;
		logic [`EESPI_PAGE-1:0] mask;
	} eespi_res_t;

	typedef struct packed {
		logic so;
		logic oe_n;
	} eespi_tx_t;

	// ************************************************************
	// System side
	// ************************************************************
	typedef struct packed {
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		logic wp_s1;
		logic wp_s2;
		logic seq_seen;
		eespi_status_t stat;
		logic [`EESPI_TMR_W-1:0] timer;
		logic copy_en;
		logic [7:0] copy_idx;
		logic id_tgt;
		logic [`EESPI_ADDR_W-1:0] cbase;
	} eespi_sys_t;

endpackage

/* logic/eespi_spi_eeprom.sv */
`timescale 1ns/10ps
`include "eespi_defines.svh"

// Overview of operation
// - Input bit sampled on serial clock rising edge; modes (0,0) and (1,1).
// - Output bit changes on serial clock falling edge.
// - Select high: output floats, device idle unless programming.
// - First eight bits form the opcode; unknown opcodes ignored.
// - Opcodes: set enable 06h, clear enable 04h, read status 05h.
// - Opcodes: write status 01h, read memory 03h, write memory 02h.
// - Status bit 0 is busy while programming; host cannot write it.
// - Write-enable latch set and cleared by its two commands.
// - Block-protect bits select none, top quarter, top half or all.
// - Writes need the latch; status write also blocked by guard.
// - No memory write lands in the protected range.
// - Page select routes access to id page; cleared after access.
// - Page lock, once set, makes id page read-only until reset.
// - Setting select and lock together leaves both unchanged.
// - Status byte layout, bit 5 always reads zero.
// - Latch starts cleared; needed before any write.
// - Latch set only if select rises right after opcode.
// - Write: opcode, 24-bit address, data; low 17 bits used.
// - Programming starts only on select rise after valid write.
// - While busy only read status is served.
// - Up to 256 data bytes, wrapping within the page.
// - Latch clears when programming completes.
// - Reads stream bytes, address incrementing and wrapping.
// - Pause floats the output and ignores input.
module eespi_spi_eeprom #(
	parameter int unsigned PROG_CYCLES = `EESPI_T_WC_CYC
) (
	// System
	input wire logic sys_clk,
	input wire logic resetn,
	// Serial link
	input wire logic link_sck,
	input wire logic link_cs_n,
	input wire logic link_si,
	input wire logic link_hold_n,
	input wire logic link_wp_n,
	output logic link_so,
	output logic link_so_oe_n
);
	import eespi_pkg::*;
	localparam logic [`EESPI_TMR_W-1:0] TIMER_LAST =
		`EESPI_TMR_W'(PROG_CYCLES - 1);
	localparam eespi_frame_t FR_RST = '0;
	localparam eespi_res_t RS_RST = '0;
	localparam eespi_sys_t SY_RST = '0;
	localparam eespi_tx_t TX_RST = '{so: 1'b0, oe_n: 1'b1};

	// ************************************************************
	// Storage
	// ************************************************************
	// Array write port on sys_clk, read port on link_sck
	logic [7:0] mem_main [0:`EESPI_MEM_BYTES-1];
	logic [7:0] mem_id [0:`EESPI_PAGE-1];
	logic [7:0] pbuf [0:`EESPI_PAGE-1];
	eespi_frame_t fr, fr_nxt;
	eespi_res_t rs, rs_nxt;
	eespi_tx_t tx, tx_nxt;
	eespi_sys_t sy, sy_nxt;
	logic pb_we;
	logic [7:0] pb_idx;
	logic [7:0] pb_dat;
	logic mem_we;
	logic [`EESPI_ADDR_W-1:0] mem_a;
	logic cs_rise;
	logic [1:0] bp;

	function automatic logic prot_hit(input logic [1:0] b,
		input logic [`EESPI_ADDR_W-1:0] a);
		case (b)
			`EESPI_BP_QTR: prot_hit = (a >= `EESPI_PROT_QTR);
			`EESPI_BP_HALF: prot_hit = (a >= `EESPI_PROT_HALF);
			`EESPI_BP_FULL: prot_hit = 1'b1;
			default: prot_hit = 1'b0;
		endcase
	endfunction
	// Status byte with bit 5 forced low
	function automatic logic [7:0] stat_byte(input eespi_status_t s);
		stat_byte = s;
		stat_byte[`EESPI_SB_ZERO] = 1'b0;
	endfunction
	function automatic logic [7:0] rd_byte(input logic sel,
		input logic [`EESPI_ADDR_W-1:0] a);
		rd_byte = sel ? mem_id[a[7:0]] : mem_main[a];
	endfunction
	// ************************************************************
	// Link domain, rising edge
	// ************************************************************
	always_comb begin
		logic [7:0] sh_new;
		logic [`EESPI_ADDR_W-1:0] a_new;
		logic [`EESPI_ADDR_W-1:0] a_inc;
		logic sel;
		sh_new = {fr.sh[6:0], link_si};
		a_new = {fr.addr[8:0], sh_new};
		sel = fr.stat_s2.id_page_select;
		a_inc = sel ? {fr.addr[`EESPI_ADDR_W-1:8], fr.addr[7:0] + 8'h01} :
			fr.addr + `EESPI_ADDR_W'(1);
		fr_nxt = fr;
		rs_nxt = rs;
		pb_we = 1'b0;
		pb_idx = fr.addr[7:0];
		pb_dat = sh_new;
		fr_nxt.stat_s1 = sy.stat;
		fr_nxt.stat_s2 = fr.stat_s1;
		// Clocks ignored while deselected or paused
		if (link_hold_n && !link_cs_n) begin
			fr_nxt.sh = sh_new;
			fr_nxt.bitcnt = fr.bitcnt + 3'h1;
			// Any further clock spoils the latch set
			rs_nxt.exact = 1'b0;
			if (fr.st == LK_OPC && fr.bitcnt == 3'h0) begin
				rs_nxt.seq = ~rs.seq;
				rs_nxt.cmd = CMD_NONE;
				rs_nxt.stat_full = 1'b0;
			end
			if (fr.bitcnt == 3'h7) begin
				unique case (fr.st)
					LK_OPC: begin
						fr_nxt.st = LK_IGN;
						if (!fr.stat_s2.busy ||
							sh_new == `EESPI_OPC_RD_STAT) begin
							case (sh_new)
								`EESPI_OPC_SET_WE: begin
									rs_nxt.cmd = CMD_SET_WE;
									rs_nxt.exact = 1'b1;
								end
								`EESPI_OPC_CLR_WE: rs_nxt.cmd = CMD_CLR_WE;
								`EESPI_OPC_RD_STAT: begin
									fr_nxt.st = LK_RSTAT;
									fr_nxt.tx = stat_byte(fr.stat_s2);
								end
								`EESPI_OPC_WR_STAT: begin
									rs_nxt.cmd = CMD_WR_STAT;
									fr_nxt.st = LK_WSTAT;
								end
								`EESPI_OPC_RD_MEM: begin
									rs_nxt.cmd = CMD_RD_MEM;
									fr_nxt.st = LK_ADDR;
								end
								`EESPI_OPC_WR_MEM: begin
									rs_nxt.cmd = CMD_WR_MEM;
									rs_nxt.mask = '0;
									fr_nxt.st = LK_ADDR;
								end
								default: fr_nxt.st = LK_IGN;
							endcase
						end
					end
					LK_ADDR: begin
						fr_nxt.addr = a_new;
						fr_nxt.bytecnt = fr.bytecnt + 2'h1;
						if (fr.bytecnt == `EESPI_ADDR_LAST) begin
							if (rs.cmd == CMD_RD_MEM) begin
								fr_nxt.st = LK_RDATA;
								fr_nxt.tx = rd_byte(sel, a_new);
							end else begin
								fr_nxt.st = LK_WDATA;
								rs_nxt.wbase = a_new;
								rs_nxt.mask = '0;
							end
						end
					end
					LK_WDATA: begin
						// Load page buffer, wrap in page
						pb_we = 1'b1;
						rs_nxt.mask[fr.addr[7:0]] = 1'b1;
						fr_nxt.addr[7:0] = fr.addr[7:0] + 8'h01;
					end
					LK_RDATA: begin
						fr_nxt.addr = a_inc;
						fr_nxt.tx = rd_byte(sel, a_inc);
					end
					LK_RSTAT: fr_nxt.tx = stat_byte(fr.stat_s2);
					LK_WSTAT: begin
						rs_nxt.stat_val = sh_new;
						rs_nxt.stat_full = 1'b1;
						fr_nxt.st = LK_IGN;
					end
					LK_IGN: fr_nxt.st = LK_IGN;
				endcase
			end
		end
	end
	// Select high restarts the frame logic
	always_ff @(posedge link_sck or posedge link_cs_n or negedge resetn) begin
		if (!resetn || link_cs_n) begin
			fr <= FR_RST;
		end else begin
			fr <= fr_nxt;
		end
	end
	// Results outlive the frame so the system side can read them
	always_ff @(posedge link_sck or negedge resetn) begin
		if (!resetn) begin
			rs <= RS_RST;
		end else begin
			rs <= rs_nxt;
		end
	end
	always_ff @(posedge link_sck) begin
		if (pb_we) begin
			pbuf[pb_idx] <= pb_dat;
		end
	end

	// ************************************************************
	// Link domain, falling edge
	// ************************************************************
	always_comb begin
		tx_nxt.oe_n = !(fr.st == LK_RDATA || fr.st == LK_RSTAT);
		tx_nxt.so = fr.tx[~fr.bitcnt];
	end
	always_ff @(negedge link_sck or posedge link_cs_n or negedge link_hold_n
		or negedge resetn) begin
		if (!resetn || link_cs_n || !link_hold_n) begin
			tx <= TX_RST;
		end else begin
			tx <= tx_nxt;
		end
	end

	assign link_so = tx.so;
	assign link_so_oe_n = tx.oe_n;
	// ************************************************************
	// System domain
	// ************************************************************
	// Link results are stable once select has risen and synced
	assign cs_rise = sy.cs_s2 && !sy.cs_s3;
	assign bp = {sy.stat.block_protect_hi, sy.stat.block_protect_lo};
	assign mem_a = {sy.cbase[`EESPI_ADDR_W-1:8], sy.copy_idx};
	always_comb begin
		logic ok;
		sy_nxt = sy;
		mem_we = 1'b0;
		ok = 1'b0;
		sy_nxt.cs_s1 = link_cs_n;
		sy_nxt.cs_s2 = sy.cs_s1;
		sy_nxt.cs_s3 = sy.cs_s2;
		sy_nxt.wp_s1 = link_wp_n;
		sy_nxt.wp_s2 = sy.wp_s1;
		if (cs_rise) begin
			sy_nxt.seq_seen = rs.seq;
		end
		if (sy.stat.busy) begin
			sy_nxt.timer = sy.timer + `EESPI_TMR_W'(1);
			if (sy.copy_en) begin
				mem_we = rs.mask[sy.copy_idx];
				sy_nxt.copy_idx = sy.copy_idx + 8'h01;
				sy_nxt.copy_en = (sy.copy_idx != 8'hFF);
			end
			if (sy.timer == TIMER_LAST) begin
				sy_nxt.stat.busy = 1'b0;
				sy_nxt.stat.write_enable_latch = 1'b0;
				sy_nxt.copy_en = 1'b0;
			end
		// Frames ending while busy change nothing
		end else if (cs_rise && rs.seq != sy.seq_seen) begin
			unique case (rs.cmd)
				CMD_SET_WE: begin
					// Only on a clean end after opcode
					if (rs.exact) begin
						sy_nxt.stat.write_enable_latch = 1'b1;
					end
				end
				CMD_CLR_WE: sy_nxt.stat.write_enable_latch = 1'b0;
				CMD_WR_STAT: begin
					// Latch and guard gate status writes
					if (rs.stat_full && sy.stat.write_enable_latch &&
						!(sy.stat.guard_enable && !sy.wp_s2)) begin
						sy_nxt.stat.guard_enable = rs.stat_val[`EESPI_SB_GUARD];
						sy_nxt.stat.block_protect_hi =
							rs.stat_val[`EESPI_SB_BP_HI];
						sy_nxt.stat.block_protect_lo =
							rs.stat_val[`EESPI_SB_BP_LO];
						// Both set at once: neither changes
						if (!(rs.stat_val[`EESPI_SB_IDSEL] &&
							rs.stat_val[`EESPI_SB_LOCK])) begin
							sy_nxt.stat.id_page_select =
								rs.stat_val[`EESPI_SB_IDSEL];
							sy_nxt.stat.id_page_lock = sy.stat.id_page_lock |
								rs.stat_val[`EESPI_SB_LOCK];
						end
						sy_nxt.stat.busy = 1'b1;
						sy_nxt.timer = '0;
					end
				end
				CMD_RD_MEM: begin
					sy_nxt.stat.id_page_select = 1'b0;
				end
				CMD_WR_MEM: begin
					if (sy.stat.id_page_select) begin
						ok = !sy.stat.id_page_lock && !prot_hit(bp,
							{9'h000, rs.wbase[7:0]});
					end else begin
						ok = !prot_hit(bp, rs.wbase);
					end
					sy_nxt.stat.id_page_select = 1'b0;
					// Start only after a full data byte
					if (ok && sy.stat.write_enable_latch && |rs.mask) begin
						sy_nxt.stat.busy = 1'b1;
						sy_nxt.timer = '0;
						sy_nxt.copy_en = 1'b1;
						sy_nxt.copy_idx = 8'h00;
						sy_nxt.id_tgt = sy.stat.id_page_select;
						sy_nxt.cbase = rs.wbase;
					end
				end
				CMD_NONE: sy_nxt.stat = sy.stat;
			endcase
		end
		sy_nxt.stat.zero = 1'b0;
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sy <= SY_RST;
		end else begin
			sy <= sy_nxt;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (mem_we) begin
			if (sy.id_tgt) begin
				mem_id[sy.copy_idx] <= pbuf[sy.copy_idx];
			end else begin
				mem_main[mem_a] <= pbuf[sy.copy_idx];
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_prog_start: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(sy.stat.busy) |-> $past(cs_rise))
		else $error("programming began without select rise");
	a_wel_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(sy.stat.busy) |-> $past(sy.stat.write_enable_latch))
		else $error("programming began with latch clear");
	a_wel_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
		$fell(sy.stat.busy) |-> !sy.stat.write_enable_latch)
		else $error("latch still set after programming");
	a_busy_time: assert property (@(posedge sys_clk) disable iff (!resetn)
		$fell(sy.stat.busy) |-> $past(sy.timer) == TIMER_LAST)
		else $error("busy ended at wrong count");
	a_lock_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
		sy.stat.id_page_lock |=> sy.stat.id_page_lock)
		else $error("page lock was cleared");
	a_sel_lock_pair: assert property (@(posedge sys_clk) disable iff (!resetn)
		!($rose(sy.stat.id_page_select) && $rose(sy.stat.id_page_lock)))
		else $error("select and lock set together");
	a_prot_block: assert property (@(posedge sys_clk) disable iff (!resetn)
		mem_we && !sy.id_tgt |-> !prot_hit(bp, mem_a))
		else $error("write into protected range");
	a_busy_ignore: assert property (@(posedge sys_clk) disable iff (!resetn)
		sy.stat.busy && cs_rise && sy.timer != TIMER_LAST |=> $stable(sy.stat))
		else $error("command acted on while busy");
	a_sel_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
		cs_rise && !sy.stat.busy && rs.seq != sy.seq_seen &&
		(rs.cmd == CMD_RD_MEM || rs.cmd == CMD_WR_MEM)
		|=> !sy.stat.id_page_select)
		else $error("page select not cleared after access");
	a_zero_bit: assert property (@(posedge link_sck) disable iff (!resetn)
		fr.st == LK_RSTAT |-> !fr.tx[`EESPI_SB_ZERO])
		else $error("status bit 5 not zero");

endmodule

/* dv/eespi_host_model.sv */
`timescale 1ns/10ps
// ************************************************************
// Host end of the serial link, modes (0,0) and (1,1)
// ************************************************************
module eespi_host_model (
	// Serial link
	output logic link_sck,
	output logic link_cs_n,
	output logic link_si,
	output logic link_hold_n,
	// Device answer
	input wire logic link_so,
	input wire logic link_so_oe_n
);
	logic drove;
	logic idle_hi;

	initial begin
		idle_hi = 1'b0;
		link_sck = 1'b0;
		link_cs_n = 1'b1;
		link_si = 1'b0;
		link_hold_n = 1'b1;
		drove = 1'b0;
	end

	task automatic open_frame();
		drove = 1'b0;
		#81.3;
		link_cs_n = 1'b0;
		#80;
	endtask

	task automatic close_frame();
		#80;
		link_cs_n = 1'b1;
		// Released line flips so a stale bit is never mistaken for data
		link_si = ~link_si;
		#400;
	endtask

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			link_sck = 1'b0;
			link_si = tx[i];
			#80;
			link_sck = 1'b1;
			rx[i] = link_so_oe_n ? 1'bx : link_so;
			drove = drove | ~link_so_oe_n;
			#80;
		end
		link_sck = idle_hi;
	endtask

	// Idle clock level picks mode (0,0) or (1,1)
	task automatic set_mode(input logic hi);
		idle_hi = hi;
		link_sck = hi;
		#160;
	endtask

	task automatic set_pause(input logic on);
		#40;
		link_hold_n = ~on;
		link_si = ~link_si;
		#40;
	endtask
endmodule

/* dv/eespi_spi_eeprom_tb_top.sv */
`timescale 1ns/10ps
// ************************************************************
// Bench top
// ************************************************************
module eespi_spi_eeprom_tb_top;
	import eespi_pkg::*;
	logic sys_clk;
	logic resetn;
	logic link_wp_n;
	logic link_sck, link_cs_n, link_si, link_hold_n;
	logic link_so, link_so_oe_n;
	int fails;
	int total_checks;
	logic [7:0] r0;
	logic [7:0] r1;

	// Long enough to read status twice while still busy
	eespi_spi_eeprom #(.PROG_CYCLES(3000)) i_eespi_spi_eeprom (
		.sys_clk(sys_clk), .resetn(resetn), .link_sck(link_sck),
		.link_cs_n(link_cs_n), .link_si(link_si),
		.link_hold_n(link_hold_n), .link_wp_n(link_wp_n),
		.link_so(link_so), .link_so_oe_n(link_so_oe_n));

	eespi_host_model i_eespi_host_model (
		.link_sck(link_sck), .link_cs_n(link_cs_n), .link_si(link_si),
		.link_hold_n(link_hold_n), .link_so(link_so),
		.link_so_oe_n(link_so_oe_n));

	initial sys_clk = 1'b0;
	always #2.5 sys_clk = ~sys_clk;

	task automatic conclude();
		$display("Checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic mem(input logic [7:0] op, input logic [23:0] a,
		input int n, input logic [7:0] d0, input logic [7:0] d1);
		i_eespi_host_model.open_frame();
		i_eespi_host_model.xfer(op, r0);
		if (n >= 0) begin
			i_eespi_host_model.xfer(a[23:16], r0);
			i_eespi_host_model.xfer(a[15:8], r0);
			i_eespi_host_model.xfer(a[7:0], r0);
		end
		if (n > 0) i_eespi_host_model.xfer(d0, r0);
		if (n > 1) i_eespi_host_model.xfer(d1, r1);
		i_eespi_host_model.close_frame();
	endtask

	task automatic cmd(input logic [7:0] op);
		mem(op, 24'h000000, -1, 8'h00, 8'h00);
	endtask

	task automatic rd_stat();
		i_eespi_host_model.open_frame();
		i_eespi_host_model.xfer(8'h05, r0);
		i_eespi_host_model.xfer(8'h00, r0);
		i_eespi_host_model.close_frame();
	endtask

	task automatic wait_idle();
		for (int n = 0; n < 20; n++) begin
			rd_stat();
			if (r0[0] === 1'b0) return;
		end
		fails++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, r0, 8'h00);
		conclude();
	endtask

	task automatic wr_stat(input logic [7:0] v);
		cmd(8'h06);
		i_eespi_host_model.open_frame();
		i_eespi_host_model.xfer(8'h01, r0);
		i_eespi_host_model.xfer(v, r0);
		i_eespi_host_model.close_frame();
		wait_idle();
	endtask

	task automatic t_latch();
		rd_stat();
		cmp_byte(r0, 8'h00); // starts cleared
		mem(8'h02, 24'h000010, 1, 8'h77, 8'h00);
		rd_stat();
		cmp_byte(r0, 8'h00); // no write without latch
		cmd(8'h06);
		rd_stat();
		cmp_byte(r0, 8'h02); // latch set
		cmd(8'h04);
		rd_stat();
		cmp_byte(r0, 8'h00); // latch cleared
		mem(8'h06, 24'h000000, 0, 8'h00, 8'h00);
		rd_stat();
		cmp_byte(r0, 8'h00); // late select rise
		mem(8'hFF, 24'h000000, 1, 8'h00, 8'h00);
		cmp_bit(i_eespi_host_model.drove, 1'b0); // unknown opcode
		cmp_bit(link_so_oe_n, 1'b1); // output off
		$display("Test latch done");
	endtask

	task automatic t_write();
		cmd(8'h06);
		mem(8'h02, 24'hFE00FF, 2, 8'hA5, 8'h5A);
		rd_stat();
		cmp_byte(r0, 8'h03); // busy after rise
		mem(8'h03, 24'h0000FF, 1, 8'h00, 8'h00);
		cmp_bit(i_eespi_host_model.drove, 1'b0); // read ignored
		rd_stat();
		cmp_bit(r0[0], 1'b1); // still busy
		wait_idle();
		rd_stat();
		cmp_byte(r0, 8'h00); // latch auto clear
		cmd(8'h06);
		mem(8'h02, 24'h01FFFF, 2, 8'h3C, 8'hC3);
		wait_idle();
		mem(8'h03, 24'h01FFFF, 2, 8'h00, 8'h00);
		cmp_byte(r0, 8'h3C); // read back
		cmp_byte(r1, 8'h5A); // wrap to lowest
		mem(8'h03, 24'h01FF00, 1, 8'h00, 8'h00);
		cmp_byte(r0, 8'hC3); // page wrap
		mem(8'h03, 24'h0000FF, 1, 8'h00, 8'h00);
		cmp_byte(r0, 8'hA5); // upper address ignored
		$display("Test write done");
	endtask

	task automatic t_protect();
		wr_stat(8'h04);
		rd_stat();
		cmp_byte(r0, 8'h04); // quarter protect
		cmd(8'h06);
		mem(8'h02, 24'h018000, 1, 8'h11, 8'h00);
		rd_stat();
		cmp_bit(r0[0], 1'b0); // protected refused
		cmd(8'h06);
		mem(8'h02, 24'h017FFF, 1, 8'h22, 8'h00);
		rd_stat();
		cmp_bit(r0[0], 1'b1); // just below accepted
		wait_idle();
		wr_stat(8'h84);
		@(negedge sys_clk) link_wp_n = 1'b0;
		wr_stat(8'h00);
		rd_stat();
		cmp_byte(r0, 8'h86); // guard blocks status
		@(negedge sys_clk) link_wp_n = 1'b1;
		wr_stat(8'h50);
		rd_stat();
		cmp_byte(r0, 8'h00); // both left unchanged
		wr_stat(8'h41);
		rd_stat();
		cmp_byte(r0, 8'h40); // busy not writable
		mem(8'h03, 24'h000000, 1, 8'h00, 8'h00);
		rd_stat();
		cmp_byte(r0, 8'h00); // select auto clear
		wr_stat(8'h10);
		wr_stat(8'h40);
		rd_stat();
		cmp_byte(r0, 8'h50); // layout with lock
		cmd(8'h06);
		mem(8'h02, 24'h000000, 1, 8'h33, 8'h00);
		rd_stat();
		cmp_bit(r0[0], 1'b0); // locked page refused
		$display("Test protect done");
	endtask

	task automatic t_mode3();
		i_eespi_host_model.set_mode(1'b1);
		rd_stat();
		cmp_byte(r0, 8'h12); // status in mode (1,1)
		mem(8'h03, 24'h0000FF, 1, 8'h00, 8'h00);
		cmp_byte(r0, 8'hA5); // read in mode (1,1)
		i_eespi_host_model.set_mode(1'b0);
		$display("Test mode3 done");
	endtask

	task automatic t_hold();
		i_eespi_host_model.open_frame();
		i_eespi_host_model.xfer(8'h05, r0);
		#20;
		cmp_bit(link_so_oe_n, 1'b0); // driving status
		i_eespi_host_model.set_pause(1'b1);
		cmp_bit(link_so_oe_n, 1'b1); // paused output off
		i_eespi_host_model.set_pause(1'b0);
		i_eespi_host_model.close_frame();
		$display("Test hold done");
	endtask

	initial begin
		fails = 0;
		total_checks = 0;
		resetn = 1'b0;
		link_wp_n = 1'b1;
		repeat (5) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (4) @(negedge sys_clk);
		t_latch();
		t_write();
		t_protect();
		t_mode3();
		t_hold();
		conclude();
	end
endmodule
